// *** dv/hbee_agent.sv ***
// Far-side model: a PCI agent that pulses the parity and system error pins.
// Assumes the bench asks for an event with a one-cycle go pulse.
`timescale 1ns/1ps
module hbee_agent
(
  // Clock and requests.
  input  wire logic clk_in,
  input  wire logic perr_go_in,
  input  wire logic serr_go_in,
  // Open-drain pins, seen through their pull-ups.
  output logic      perr_n_out,
  output logic      serr_n_out
);
  ////////////////////////////////////////////////////////////////////////
  logic [2:0] perr_cnt = 3'h0; // Cycles left with the pin pulled low.
  logic [2:0] serr_cnt = 3'h0; // Cycles left with the pin pulled low.

  // Each request pulls its pin low for four cycles, then the pull-up wins.
  // A plain process, so that the counters may start from a known value.
  always @(posedge clk_in)
  begin
    if (perr_go_in)
      perr_cnt <= 3'h4;
    else if (perr_cnt != 3'h0)
      perr_cnt <= perr_cnt - 3'h1;
    if (serr_go_in)
      serr_cnt <= 3'h4;
    else if (serr_cnt != 3'h0)
      serr_cnt <= serr_cnt - 3'h1;
  end

  // A released pin reads high.
  assign perr_n_out = (perr_cnt == 3'h0);
  assign serr_n_out = (serr_cnt == 3'h0);
endmodule

// *** dv/host_bridge_error_endian_bench.sv ***
// Self-checking bench for the error handling and byte-order block.
// Assumes the agent model drives the PCI error pins.
`timescale 1ns/1ps
module host_bridge_error_endian_bench;
  import hbee_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic        clk_in = 1'b0;     // Bridge clock.
  logic        resetn_in = 1'b0;  // Board reset.
  logic        ce_in = 1'b1;      // Clock enable, low freezes the block.
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  hbee_cyc_t   cyc_in = '0;
  logic [63:0] raw_data_in = 64'h0;
  logic [63:0] fixed_data_in = 64'h0;
  logic        mem_we_out, cyc_done_out, transfer_error_ack_out;
  logic [63:0] cyc_data_out, data_in = 64'h0, data_out;
  hbee_tgt_t   tgt_in = HBEE_TGT_LOCAL;
  hbee_size_t  size_in = HBEE_SZ_BYTE;
  logic [2:0]  addr_in = 3'h0, addr_out;
  logic        perr_n, serr_n, perr_go = 1'b0, serr_go = 1'b0;
  logic [6:0]  irq_req_out;
  logic        machine_check_out;
  logic [1:0]  processor_soft_reset_out;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          seed = 32'h9600;
  logic [6:0]  m_status = 7'h0, m_irq = 7'h0, m_mck = 7'h0; // Model state.

  // Free-running 20 MHz clock.
  initial
  begin
    forever #25 clk_in = ~clk_in;
  end

  hbee_top #(.NPROC(2)) DUT (.clk_in(clk_in), .resetn_in(resetn_in),
    .ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .cyc_in(cyc_in),
    .raw_data_in(raw_data_in), .fixed_data_in(fixed_data_in),
    .mem_we_out(mem_we_out), .cyc_data_out(cyc_data_out),
    .cyc_done_out(cyc_done_out),
    .transfer_error_ack_out(transfer_error_ack_out), .tgt_in(tgt_in),
    .size_in(size_in), .addr_in(addr_in), .data_in(data_in),
    .addr_out(addr_out), .data_out(data_out), .perr_n_in(perr_n),
    .serr_n_in(serr_n), .irq_req_out(irq_req_out),
    .machine_check_out(machine_check_out),
    .processor_soft_reset_out(processor_soft_reset_out));

  hbee_agent PCI (.clk_in(clk_in), .perr_go_in(perr_go),
    .serr_go_in(serr_go), .perr_n_out(perr_n), .serr_n_out(serr_n));

  ////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register write cycle.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // One register read; data are taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask

  // Reports compare interrupt and machine-check levels with the model.
  task automatic chk_rep();
    chk(irq_req_out, m_status & m_irq);
    chk(machine_check_out, |(m_status & m_mck & HBEE_MCK_MASK));
    chk(transfer_error_ack_out, 1'b0);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bytes reversed end for end.
  function automatic logic [63:0] rev(input logic [63:0] d);
    logic [63:0] r;
    for (int b = 0; b < 8; b++)
      r[8*b +: 8] = d[8*(7-b) +: 8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Watchdog cuts a hang short.
  initial
  begin
    #(50 * 5000);
    bad_count++;
    print_verdict();
  end

  // Main sequence.
  initial
  begin
    logic [63:0] e;
    int          cause;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int a = 0; a < 5; a++)
      rd(a[3:0], 32'h0);
    chk(processor_soft_reset_out, 2'h0);
    // Report enables, random but readable back.
    m_irq = 7'($random(seed));
    m_mck = 7'($random(seed));
    wr(HBEE_REG_IRQ_EN, {25'h0, m_irq});
    wr(HBEE_REG_MCK_EN, {25'h0, m_mck});
    rd(HBEE_REG_IRQ_EN, {25'h0, m_irq});
    rd(HBEE_REG_MCK_EN, {25'h0, m_mck & HBEE_MCK_MASK});
    rd(4'hf, 32'h0);
    // Every cause on stores and loads; status cleared between rounds.
    for (int k = 0; k < 24; k++)
    begin
      cause = (k >> 1) % 6;
      if (k == 12)
      begin
        wr(HBEE_REG_STATUS, 32'h7f);
        m_status = 7'h0;
        m_irq = 7'h7f;
        m_mck = 7'h7f;
        wr(HBEE_REG_IRQ_EN, 32'h7f);
        wr(HBEE_REG_MCK_EN, 32'h7f);
      end
      @(posedge clk_in);
      raw_data_in <= {$random(seed), $random(seed)};
      fixed_data_in <= {$random(seed), $random(seed)};
      cyc_in <= '{1'b1, k[0], cause == 1, cause == 2, cause == 3,
                  cause == 4, cause == 5};
      @(posedge clk_in);
      cyc_in <= '0;
      #1;
      if (cause != 0)
        m_status[cause-1] = 1'b1;
      chk(cyc_done_out, 1'b1);
      chk(mem_we_out, k[0] && cause < 2);
      e = (cause == 1) ? fixed_data_in : raw_data_in;
      if (cause >= 4 && !k[0])
        e = '1;
      if (cause != 3 && !(k[0] && cause >= 2))
        chk(cyc_data_out, e);
      chk_rep();
    end
    // Pin events from the agent.
    @(posedge clk_in);
    perr_go <= 1'b1;
    @(posedge clk_in);
    perr_go <= 1'b0;
    serr_go <= 1'b1;
    @(posedge clk_in);
    serr_go <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    m_status[HBEE_ERR_PERR] = 1'b1;
    m_status[HBEE_ERR_SERR] = 1'b1;
    chk_rep();
    rd(HBEE_REG_STATUS, {25'h0, m_status});
    wr(HBEE_REG_STATUS, 32'h7f);
    m_status = 7'h0;
    #1;
    chk_rep();
    // Soft reset bits written with each of the four values 0 to 3 in turn.
    for (int p = 0; p < 4; p++)
    begin
      wr(HBEE_REG_PROC_INIT, p);
      #1;
      chk(processor_soft_reset_out, p[1:0]);
    end
    // Clock enable low freezes all state: a write then has no effect.
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(HBEE_REG_PROC_INIT, 32'h0);
    #1;
    chk(processor_soft_reset_out, 2'h3);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd(HBEE_REG_PROC_INIT, 32'h3);
    // Byte-order path over both modes, every target and size.
    for (int le = 0; le < 2; le++)
    begin
      wr(HBEE_REG_MODE, le);
      for (int t = 0; t < 12; t++)
      begin
        @(posedge clk_in);
        tgt_in <= hbee_tgt_t'(t / 4);
        size_in <= hbee_size_t'(t % 4);
        addr_in <= 3'($random(seed));
        data_in <= {$random(seed), $random(seed)};
        @(posedge clk_in);
        #1;
        e = (le == 0 && t >= 4) ? rev(data_in) : data_in;
        chk(data_out, e);
        e[2:0] = addr_in;
        if (le == 1 && t >= 4)
          e[2:0] = addr_in ^ ((t % 4 == 0) ? 3'h7 : (t % 4 == 1) ? 3'h6 :
                              (t % 4 == 2) ? 3'h4 : 3'h0);
        chk(addr_out, e[2:0]);
      end
    end
    print_verdict();
  end
endmodule

// *** src/hbee_pkg.sv ***
// Package for the host bridge error and byte-order block.
// Assumes a 64-bit data path and a small plain register port.
package hbee_pkg;

  // Register offsets of the plain register port.
  localparam logic [3:0] HBEE_REG_IRQ_EN   = 4'h0; // Interrupt enables.
  localparam logic [3:0] HBEE_REG_MCK_EN   = 4'h1; // Machine-check enables.
  localparam logic [3:0] HBEE_REG_STATUS   = 4'h2; // Sticky error causes.
  localparam logic [3:0] HBEE_REG_PROC_INIT = 4'h3; // Processor soft reset.
  localparam logic [3:0] HBEE_REG_MODE     = 4'h4; // Bit 0: little-endian.

  // Field positions of the error cause vector.
  localparam int HBEE_ERR_SBE  = 0; // Single-bit ECC.
  localparam int HBEE_ERR_DBE  = 1; // Double-bit ECC.
  localparam int HBEE_ERR_TMO  = 2; // Bus timeout.
  localparam int HBEE_ERR_TABT = 3; // Target abort.
  localparam int HBEE_ERR_MABT = 4; // Master abort.
  localparam int HBEE_ERR_PERR = 5; // Parity error detected.
  localparam int HBEE_ERR_SERR = 6; // System error detected.
  localparam int HBEE_NERR     = 7; // Number of causes.

  // Reset value and machine-check mask.
  localparam logic [6:0] HBEE_EN_RST   = 7'h00;
  localparam logic [6:0] HBEE_MCK_MASK = 7'h7e; // Single-bit is excluded.

  // Access sizes.
  typedef enum logic [1:0]
  {
    HBEE_SZ_BYTE  = 2'h0,
    HBEE_SZ_HALF  = 2'h1,
    HBEE_SZ_WORD  = 2'h2,
    HBEE_SZ_DWORD = 2'h3
  } hbee_size_t;

  // Address targets of an access.
  typedef enum logic [1:0]
  {
    HBEE_TGT_LOCAL = 2'h0, // Controller regs, memory, flash, system regs.
    HBEE_TGT_PCI   = 2'h1, // Processor access headed to PCI.
    HBEE_TGT_PMEM  = 2'h2  // PCI access headed to memory.
  } hbee_tgt_t;

  // Completion of one bus cycle as seen by the error logic.
  typedef struct packed
  {
    logic       valid;  // Cycle completes this clock.
    logic       store;  // 1 for store, 0 for load.
    logic       sbe;    // Single-bit ECC error seen.
    logic       dbe;    // Double-bit ECC error seen.
    logic       tmo;    // Bus timeout.
    logic       tabt;   // PCI target abort.
    logic       mabt;   // PCI master abort.
  } hbee_cyc_t;

endpackage

// *** src/hbee_resp.sv ***
// Load/store outcome unit: picks write data, write enable and read data.
// Assumes the top registers its outputs.
`timescale 1ns/1ps
module hbee_resp
  import hbee_pkg::*;
(
  // Cycle and data.
  input  wire hbee_cyc_t   cyc_in,
  input  wire logic [63:0] raw_in,
  input  wire logic [63:0] fixed_in,
  // Outcome.
  output logic             mem_we_out,
  output logic [63:0]      data_out,
  output logic             done_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Outcome per cause; every cycle ends normally.
  always_comb
  begin
    mem_we_out = 1'b0;
    data_out   = raw_in;
    done_out   = cyc_in.valid;
    if (cyc_in.valid && cyc_in.store)
    begin
      // Bus errors and double-bit drop the write.
      mem_we_out = !(cyc_in.dbe || cyc_in.tmo || cyc_in.tabt
                     || cyc_in.mabt);
      // Corrected data is written on a single-bit error.
      data_out = cyc_in.sbe ? fixed_in : raw_in;
    end
    else if (cyc_in.valid)
    begin
      if (cyc_in.tabt || cyc_in.mabt)
      begin
        data_out = '1;
      end
      else if (cyc_in.dbe || cyc_in.tmo)
      begin
        data_out = raw_in;
      end
      else if (cyc_in.sbe)
      begin
        data_out = fixed_in;
      end
    end
  end

endmodule

// *** src/hbee_swap.sv ***
// Byte-order unit: swaps bytes or rearranges low address bits.
// Assumes a purely combinational use by the bridge top.
`timescale 1ns/1ps
module hbee_swap
  import hbee_pkg::*;
(
  // Access description.
  input  wire logic       little_in,
  input  wire hbee_tgt_t  tgt_in,
  input  wire hbee_size_t size_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [63:0] data_in,
  // Converted access.
  output logic [2:0]      addr_out,
  output logic [63:0]     data_out
);

  // Returns the low address xor mask for an access size.
  function automatic logic [2:0] hbee_munge(input hbee_size_t sz);
    case (sz)
      HBEE_SZ_BYTE:  hbee_munge = 3'h7;
      HBEE_SZ_HALF:  hbee_munge = 3'h6;
      HBEE_SZ_WORD:  hbee_munge = 3'h4;
      default:       hbee_munge = 3'h0;
    endcase
  endfunction

  // Reverses the eight bytes of a doubleword.
  function automatic logic [63:0] hbee_bswap(input logic [63:0] d);
    for (int i = 0; i < 8; i++)
    begin
      hbee_bswap[i*8 +: 8] = d[(7-i)*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Local targets pass untouched in both modes.
  always_comb
  begin
    addr_out = addr_in;
    data_out = data_in;
    if (tgt_in != HBEE_TGT_LOCAL)
    begin
      if (little_in)
      begin
        // Address is reverse-rearranged or rearranged; same xor both ways.
        addr_out = addr_in ^ hbee_munge(size_in);
      end
      else
      begin
        // Bytes are swapped both ways to keep address invariance.
        data_out = hbee_bswap(data_in);
      end
    end
  end

endmodule

// *** src/hbee_top.sv ***
// Top of the host bridge error handling and byte-order block.
// Assumes synchronous inputs from bridge logic; PERR and SERR are pins.
// Function
// - Store single-bit ECC writes corrected data.
// - Load single-bit ECC returns corrected data.
// - Store double-bit ECC ends normally, no write.
// - Load double-bit ECC returns uncorrected data.
// - Store bus errors drop data, end normally.
// - Load timeout returns any data, completes.
// - Load aborts return all ones, end normally.
// - Interrupt per cause only when enabled.
// - Machine check per non-single-bit cause when enabled.
// - Transfer error acknowledge is never asserted.
// - Software sets processor soft reset bits.
// - Local targets always appear big-endian.
// - Big-endian mode swaps bytes both directions.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module hbee_top
  import hbee_pkg::*;
#(
  parameter int NPROC = 2
)
(
  // Clock, reset and enable.
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             ce_in,
  // Register port.
  input  wire logic [3:0]       reg_addr_in,
  input  wire logic [31:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic [31:0]           reg_rdata_out,
  // Bus cycle completion.
  input  wire hbee_cyc_t        cyc_in,
  input  wire logic [63:0]      raw_data_in,
  input  wire logic [63:0]      fixed_data_in,
  output logic                  mem_we_out,
  output logic [63:0]           cyc_data_out,
  output logic                  cyc_done_out,
  output logic                  transfer_error_ack_out,
  // Byte-order path.
  input  wire hbee_tgt_t        tgt_in,
  input  wire hbee_size_t       size_in,
  input  wire logic [2:0]       addr_in,
  input  wire logic [63:0]      data_in,
  output logic [2:0]            addr_out,
  output logic [63:0]           data_out,
  // PCI error pins, active low.
  input  wire logic             perr_n_in,
  input  wire logic             serr_n_in,
  // Reports.
  output logic [HBEE_NERR-1:0]  irq_req_out,
  output logic                  machine_check_out,
  output logic [NPROC-1:0]      processor_soft_reset_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  logic [1:0] pin_s1;      // First stage.
  logic [1:0] pin_s2;      // Second stage.
  logic [1:0] pin_s3;      // Previous value for edge detect.

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
      pin_s3 <= 2'h3;
    end
    else if (ce_in)
    begin
      pin_s1 <= {serr_n_in, perr_n_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outcome and byte-order units.
  logic             next_we;   // Write enable of the outcome.
  logic [63:0]      next_cdat; // Data of the outcome.
  logic             next_done; // Cycle end.
  logic [2:0]       next_addr; // Converted address.
  logic [63:0]      next_dat;  // Converted data.
  logic             little;    // Little-endian mode bit.

  hbee_resp u_resp
  (
    .cyc_in     (cyc_in),
    .raw_in     (raw_data_in),
    .fixed_in   (fixed_data_in),
    .mem_we_out (next_we),
    .data_out   (next_cdat),
    .done_out   (next_done)
  );

  hbee_swap u_swap
  (
    .little_in (little),
    .tgt_in    (tgt_in),
    .size_in   (size_in),
    .addr_in   (addr_in),
    .data_in   (data_in),
    .addr_out  (next_addr),
    .data_out  (next_dat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [HBEE_NERR-1:0] irq_en;     // Interrupt enables.
  logic [HBEE_NERR-1:0] mck_en;     // Machine-check enables.
  logic [HBEE_NERR-1:0] status;     // Sticky causes.
  logic [NPROC-1:0]     proc_init;  // Soft reset bits.
  logic [HBEE_NERR-1:0] next_irq_en;
  logic [HBEE_NERR-1:0] next_mck_en;
  logic [HBEE_NERR-1:0] next_status;
  logic [NPROC-1:0]     next_proc_init;
  logic                 next_little;
  logic [31:0]          next_rdata;
  logic [HBEE_NERR-1:0] err_ev;     // Cause events this clock.

  // Gathers the cause events of this clock.
  always_comb
  begin
    err_ev = '0;
    if (cyc_in.valid)
    begin
      err_ev[HBEE_ERR_SBE]  = cyc_in.sbe;
      err_ev[HBEE_ERR_DBE]  = cyc_in.dbe;
      err_ev[HBEE_ERR_TMO]  = cyc_in.tmo;
      err_ev[HBEE_ERR_TABT] = cyc_in.tabt;
      err_ev[HBEE_ERR_MABT] = cyc_in.mabt;
    end
    // Falling edge of each pin counts as one event.
    err_ev[HBEE_ERR_PERR] = pin_s3[0] && !pin_s2[0];
    err_ev[HBEE_ERR_SERR] = pin_s3[1] && !pin_s2[1];
  end

  // Next values of the registers and the read data.
  always_comb
  begin
    next_irq_en    = irq_en;
    next_mck_en    = mck_en;
    next_proc_init = proc_init;
    next_little    = little;
    next_rdata     = 32'h0;
    next_status    = status;
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        HBEE_REG_IRQ_EN:
          next_irq_en = reg_wdata_in[HBEE_NERR-1:0];
        HBEE_REG_MCK_EN:
          next_mck_en = reg_wdata_in[HBEE_NERR-1:0] & HBEE_MCK_MASK;
        HBEE_REG_STATUS:
          next_status = status & ~reg_wdata_in[HBEE_NERR-1:0];
        HBEE_REG_PROC_INIT:
          next_proc_init = reg_wdata_in[NPROC-1:0];
        HBEE_REG_MODE:
          next_little = reg_wdata_in[0];
        default:
          next_little = little;
      endcase
    end
    // Set wins over a clear in the same clock.
    next_status = next_status | err_ev;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        HBEE_REG_IRQ_EN:    next_rdata[HBEE_NERR-1:0] = irq_en;
        HBEE_REG_MCK_EN:    next_rdata[HBEE_NERR-1:0] = mck_en;
        HBEE_REG_STATUS:    next_rdata[HBEE_NERR-1:0] = status;
        HBEE_REG_PROC_INIT: next_rdata[NPROC-1:0] = proc_init;
        HBEE_REG_MODE:      next_rdata[0] = little;
        default:            next_rdata = 32'h0;
      endcase
    end
  end

  // Registers all state but the pin synchronisers; all outputs come from here.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      irq_en                   <= HBEE_EN_RST;
      mck_en                   <= HBEE_EN_RST;
      status                   <= '0;
      proc_init                <= '0;
      little                   <= 1'b0;
      reg_rdata_out            <= 32'h0;
      mem_we_out               <= 1'b0;
      cyc_data_out             <= 64'h0;
      cyc_done_out             <= 1'b0;
      transfer_error_ack_out   <= 1'b0;
      addr_out                 <= 3'h0;
      data_out                 <= 64'h0;
      irq_req_out              <= '0;
      machine_check_out        <= 1'b0;
      processor_soft_reset_out <= '0;
    end
    else if (ce_in)
    begin
      irq_en                   <= next_irq_en;
      mck_en                   <= next_mck_en;
      status                   <= next_status;
      proc_init                <= next_proc_init;
      little                   <= next_little;
      reg_rdata_out            <= next_rdata;
      mem_we_out               <= next_we;
      cyc_data_out             <= next_cdat;
      cyc_done_out             <= next_done;
      transfer_error_ack_out   <= 1'b0;
      addr_out                 <= next_addr;
      data_out                 <= next_dat;
      irq_req_out              <= next_status & irq_en;
      machine_check_out        <= |(next_status & mck_en
                                    & HBEE_MCK_MASK);
      processor_soft_reset_out <= next_proc_init;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_no_tea: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    !transfer_error_ack_out)
    else $error("transfer error ack asserted");

  a_dbe_store_nowr: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ce_in && cyc_in.valid && cyc_in.store && cyc_in.dbe
      |=> !mem_we_out && cyc_done_out)
    else $error("double-bit store wrote memory");

  a_abort_ones: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ce_in && cyc_in.valid && !cyc_in.store && (cyc_in.tabt || cyc_in.mabt)
      |=> cyc_data_out == 64'hffff_ffff_ffff_ffff && cyc_done_out)
    else $error("abort load not all ones");

  a_sbe_fix_load: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ce_in && cyc_in.valid && !cyc_in.store && cyc_in.sbe && !cyc_in.dbe
      && !cyc_in.tmo && !cyc_in.tabt && !cyc_in.mabt
      |=> cyc_data_out == $past(fixed_data_in))
    else $error("single-bit load not corrected");

  a_sbe_fix_store: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ce_in && cyc_in.valid && cyc_in.store && cyc_in.sbe && !cyc_in.dbe
      && !cyc_in.tmo && !cyc_in.tabt && !cyc_in.mabt
      |=> mem_we_out && cyc_data_out == $past(fixed_data_in))
    else $error("single-bit store not corrected");

  a_bus_err_drop: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ce_in && cyc_in.valid && cyc_in.store
      && (cyc_in.tmo || cyc_in.tabt || cyc_in.mabt)
      |=> !mem_we_out && cyc_done_out)
    else $error("bus error store wrote memory");

  a_irq_gated: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ##1 (irq_req_out & ~$past(irq_en)) == '0)
    else $error("interrupt raised while disabled");

  a_sbe_no_mck: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    mck_en[HBEE_ERR_SBE] == 1'b0)
    else $error("single-bit machine check enabled");

  a_local_pass: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ce_in && tgt_in == HBEE_TGT_LOCAL
      |=> addr_out == $past(addr_in) && data_out == $past(data_in))
    else $error("local target altered");

  a_le_byte_xor: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ce_in && little && tgt_in != HBEE_TGT_LOCAL && size_in == HBEE_SZ_BYTE
      |=> addr_out == ($past(addr_in) ^ 3'h7))
    else $error("byte rearrange wrong");

  a_soft_reset: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ce_in && reg_wr_in && reg_addr_in == HBEE_REG_PROC_INIT
      |=> processor_soft_reset_out == $past(reg_wdata_in[NPROC-1:0]))
    else $error("soft reset not applied");

endmodule
